// ### rtl/rxles_defs.svh
// Offsets, field positions, reset values and the retry limit for the receive error status block.
`ifndef RXLES_DEFS_SVH
`define RXLES_DEFS_SVH
`define RXLES_ADDR_W 16
`define RXLES_OFF_CONTROL 16'h00C2
`define RXLES_OFF_STATUS 16'h00D0
`define RXLES_OFF_ENABLE 16'h00D1
`define RXLES_OFF_ALIGN_STATE 16'h00D2
`define RXLES_STAT_W 12
`define RXLES_BIT_DESKEW 10
`define RXLES_BIT_ECC_FATAL 9
`define RXLES_BIT_ECC_CORR 8
`define RXLES_BIT_ALIGN_LOST 6
`define RXLES_BIT_RETRY_FAIL 5
`define RXLES_BIT_PCS_ERR 4
`define RXLES_BIT_CRC_ERR 3
`define RXLES_BIT_FRAME_LOST 2
`define RXLES_STAT_VALID_MASK 12'h77C
`define RXLES_STAT_RESET 12'h000
`define RXLES_ENABLE_RESET 12'h000
`define RXLES_CONTROL_RESET 1'h0
`define RXLES_RETRY_LIMIT 4
`endif

// ### rtl/rxles_pkg.sv
// Types shared by the receive error status block.
`default_nettype none
package rxles_pkg;
   typedef enum logic [1:0] {
      RXLES_IDLE,
      RXLES_SEARCH,
      RXLES_ALIGNED
   } rxles_align_state_t;
endpackage : rxles_pkg
`default_nettype wire

// ### rtl/rxles_align_fsm.sv
// Lane alignment state machine with retry counting and self recovery.
`timescale 1ns/1ps
`default_nettype none
`include "rxles_defs.svh"
module rxles_align_fsm #(
   parameter int RETRY_LIMIT = `RXLES_RETRY_LIMIT
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Control.
   input wire logic restart,
   // Lane events.
   input wire logic sync_all_lanes,
   input wire logic align_lost,
   // Status.
   output rxles_pkg::rxles_align_state_t state,
   output logic retry_fail_pulse
);
   rxles_pkg::rxles_align_state_t state_reg;
   rxles_pkg::rxles_align_state_t state_next;
   logic [7:0] retry_reg;
   logic [7:0] retry_next;
   logic fail_next;
   logic fail_reg;

   // Next state; restart overrides everything and holds the machine idle.
   always_comb begin
      state_next = state_reg;
      retry_next = retry_reg;
      fail_next = 1'b0;
      if (restart) begin
         state_next = rxles_pkg::RXLES_IDLE;
         retry_next = 8'h00;
      end else begin
         case (state_reg)
            rxles_pkg::RXLES_IDLE: begin
               state_next = rxles_pkg::RXLES_SEARCH;
            end
            rxles_pkg::RXLES_SEARCH: begin
               if (sync_all_lanes) begin
                  state_next = rxles_pkg::RXLES_ALIGNED;
                  retry_next = 8'h00;
               end else if (align_lost) begin
                  // A skewed sync word during search is one more failed attempt, so the limit can be reached.
                  if (retry_reg != 8'hFF) begin
                     retry_next = retry_reg + 8'h01;
                  end
                  fail_next = ({1'b0, retry_reg} + 9'h001) > 9'(RETRY_LIMIT);
               end
            end
            rxles_pkg::RXLES_ALIGNED: begin
               if (align_lost) begin
                  state_next = rxles_pkg::RXLES_SEARCH;
                  if (retry_reg != 8'hFF) begin
                     retry_next = retry_reg + 8'h01;
                  end
                  // Nine bits keep a saturated count from wrapping below the limit.
                  fail_next = ({1'b0, retry_reg} + 9'h001) > 9'(RETRY_LIMIT);
               end
            end
            default: begin
               state_next = rxles_pkg::RXLES_IDLE;
            end
         endcase
      end
   end

   // State registers.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= rxles_pkg::RXLES_IDLE;
         retry_reg <= 8'h00;
         fail_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         retry_reg <= retry_next;
         fail_reg <= fail_next;
      end
   end

   assign state = state_reg;
   assign retry_fail_pulse = fail_reg;
endmodule : rxles_align_fsm
`default_nettype wire

// ### rtl/rxles_regs.sv
// Receive link control and error status register bank.
// Operation
// - While the restart bit is one the alignment machine is held idle and restarts alignment on release.
// - Bit 10 is set when lane skew exceeds the deskew capability.
// - Bit 9 is set when any lane sees an uncorrectable double-bit ECC error.
// - Bit 8 is set when any lane corrects a single-bit ECC error.
// - Bit 6 is set when, while aligned, the sync words do not arrive on all lanes in one cycle.
// - After alignment loss the machine re-aligns by itself without reset.
// - Bit 5 is set when the alignment retry count goes beyond its limit.
// - Bit 4 is set on any lane sync, metaframe or CRC-32 coding error.
// - Bit 3 is set when any lane detects a CRC error.
// - Bit 2 is set when any lane loses frame lock.
// - After frame lock loss the block resumes normal operation by itself.
// - Status flags are sticky, cleared by writing one, unchanged by zero, and reset to zero.
// - The restart bit is read-write and resets to zero.
// - An interrupt enable register at the next word matches the status layout and resets to zero.
`timescale 1ns/1ps
`default_nettype none
`include "rxles_defs.svh"
module rxles_regs #(
   parameter int NUM_LANES = 4,
   parameter int RETRY_LIMIT = `RXLES_RETRY_LIMIT
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Register port.
   input wire logic [`RXLES_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Per-lane sync words and error events.
   input wire logic [NUM_LANES-1:0] lane_deskew_over,
   input wire logic [NUM_LANES-1:0] lane_ecc_fatal,
   input wire logic [NUM_LANES-1:0] lane_ecc_corr,
   input wire logic [NUM_LANES-1:0] lane_sync_word,
   input wire logic [NUM_LANES-1:0] lane_pcs_err,
   input wire logic [NUM_LANES-1:0] checksum_error_flag,
   input wire logic [NUM_LANES-1:0] lane_frame_lost,
   // Link status and interrupt.
   output logic link_aligned,
   output logic align_restart,
   output logic irq
);
   logic control_reg;
   logic [`RXLES_STAT_W-1:0] status_reg;
   logic [`RXLES_STAT_W-1:0] status_next;
   logic [`RXLES_STAT_W-1:0] enable_reg;
   logic [`RXLES_STAT_W-1:0] enable_next;
   logic [31:0] rdata_next;
   logic irq_next;
   logic aligned_next;
   logic [`RXLES_STAT_W-1:0] events;
   logic sel_control;
   logic sel_status;
   logic sel_enable;
   logic sel_state;
   logic any_sync;
   logic all_sync;
   logic sync_skewed;
   logic align_lost_evt;
   logic retry_fail;
   rxles_pkg::rxles_align_state_t align_state;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode.
   assign sel_control = (reg_addr == `RXLES_OFF_CONTROL);
   assign sel_status = (reg_addr == `RXLES_OFF_STATUS);
   assign sel_enable = (reg_addr == `RXLES_OFF_ENABLE);
   assign sel_state = (reg_addr == `RXLES_OFF_ALIGN_STATE);

   ////////////////////////////////////////////////////////////////////////////
   // Lane consolidation; sync words seen on some lanes but not all means skew.
   assign any_sync = |lane_sync_word;
   assign all_sync = &lane_sync_word;
   assign sync_skewed = any_sync && !all_sync;
   assign align_lost_evt = sync_skewed && (align_state == rxles_pkg::RXLES_ALIGNED);

   // Event vector in status layout; reserved positions stay zero.
   always_comb begin
      events = '0;
      events[`RXLES_BIT_DESKEW] = |lane_deskew_over;
      events[`RXLES_BIT_ECC_FATAL] = |lane_ecc_fatal;
      events[`RXLES_BIT_ECC_CORR] = |lane_ecc_corr;
      events[`RXLES_BIT_ALIGN_LOST] = align_lost_evt;
      events[`RXLES_BIT_RETRY_FAIL] = retry_fail;
      events[`RXLES_BIT_PCS_ERR] = |lane_pcs_err;
      events[`RXLES_BIT_CRC_ERR] = |checksum_error_flag;
      events[`RXLES_BIT_FRAME_LOST] = |lane_frame_lost;
   end

   // Alignment machine; it re-aligns by itself after a loss, and frame lock
   // loss only flags status, so the datapath recovers once the cause is gone.
   rxles_align_fsm #(
      .RETRY_LIMIT(RETRY_LIMIT)
   ) u_align (
      .core_clk(core_clk),
      .rst(rst),
      .restart(control_reg),
      .sync_all_lanes(all_sync),
      .align_lost(sync_skewed),
      .state(align_state),
      .retry_fail_pulse(retry_fail)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sticky status: a new event wins over a write-one clear in the same cycle.
   assign status_next = ((status_reg & ~((sel_status && reg_write) ? reg_wdata[`RXLES_STAT_W-1:0] : '0))
                         | events) & `RXLES_STAT_VALID_MASK;
   // The interrupt follows the next enable too, so it never lags a mask write by a cycle.
   assign enable_next = (reg_write && sel_enable) ?
                        (reg_wdata[`RXLES_STAT_W-1:0] & `RXLES_STAT_VALID_MASK) : enable_reg;
   assign irq_next = |(status_next & enable_next);
   assign aligned_next = (align_state == rxles_pkg::RXLES_ALIGNED);

   // Read data mux.
   assign rdata_next = !reg_read ? 32'h0000_0000 :
                       sel_control ? {31'h0000_0000, control_reg} :
                       sel_status ? {20'h0_0000, status_reg} :
                       sel_enable ? {20'h0_0000, enable_reg} :
                       sel_state ? {30'h0000_0000, align_state} :
                       32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Control and enable registers.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         control_reg <= `RXLES_CONTROL_RESET;
         enable_reg <= `RXLES_ENABLE_RESET;
      end else begin
         if (reg_write && sel_control) begin
            control_reg <= reg_wdata[0];
         end
         enable_reg <= enable_next;
      end
   end

   // Status, read data and output flops.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         status_reg <= `RXLES_STAT_RESET;
         reg_rdata <= 32'h0000_0000;
         irq <= 1'b0;
         link_aligned <= 1'b0;
         align_restart <= 1'b0;
      end else begin
         status_reg <= status_next;
         reg_rdata <= rdata_next;
         irq <= irq_next;
         link_aligned <= aligned_next;
         align_restart <= control_reg;
      end
   end
endmodule : rxles_regs
`default_nettype wire

// ### tb/rxles_regs_chk.sv
// Port checks for the receive error status register bank.
`timescale 1ns/1ps
`default_nettype none
module rxles_regs_chk #(
   parameter int NUM_LANES = 4
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Register port.
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   // Lane events.
   input wire logic [NUM_LANES-1:0] lane_deskew_over,
   input wire logic [NUM_LANES-1:0] lane_ecc_fatal,
   input wire logic [NUM_LANES-1:0] lane_ecc_corr,
   input wire logic [NUM_LANES-1:0] lane_pcs_err,
   input wire logic [NUM_LANES-1:0] checksum_error_flag,
   input wire logic [NUM_LANES-1:0] lane_frame_lost,
   // Status.
   input wire logic align_restart,
   input wire logic link_aligned,
   input wire logic irq
);
   // A read of the status word.
   wire logic rd_st = reg_read && reg_addr == 16'h00D0;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // An event on any lane shows in a status read made just after it.
   deskew_flag_a: assert property ((|lane_deskew_over) ##1 rd_st |=> reg_rdata[10])
      else $error("deskew flag missing");
   ecc_fatal_a: assert property ((|lane_ecc_fatal) ##1 rd_st |=> reg_rdata[9])
      else $error("ecc fatal flag missing");
   ecc_corr_a: assert property ((|lane_ecc_corr) ##1 rd_st |=> reg_rdata[8])
      else $error("ecc corrected flag missing");
   pcs_flag_a: assert property ((|lane_pcs_err) ##1 rd_st |=> reg_rdata[4])
      else $error("coding flag missing");
   crc_flag_a: assert property ((|checksum_error_flag) ##1 rd_st |=> reg_rdata[3])
      else $error("checksum flag missing");
   frame_flag_a: assert property ((|lane_frame_lost) ##1 rd_st |=> reg_rdata[2])
      else $error("frame flag missing");
   restart_idle_a: assert property (align_restart |-> ##2 !link_aligned)
      else $error("aligned during restart");
   reserved_zero_a: assert property (rd_st |=> reg_rdata[31:11] == 21'h0 && !reg_rdata[7])
      else $error("reserved bits set");
   irq_sticky_a: assert property (irq && !reg_write |=> irq)
      else $error("interrupt dropped");
   irq_masked_a: assert property (reg_write && reg_addr == 16'h00D1 && reg_wdata[11:0] == 12'h000 |=> !irq)
      else $error("masked interrupt high");
endmodule : rxles_regs_chk
bind rxles_regs rxles_regs_chk #(.NUM_LANES(NUM_LANES)) chk (.core_clk, .rst, .reg_addr, .reg_wdata,
   .reg_write, .reg_read, .reg_rdata, .lane_deskew_over, .lane_ecc_fatal, .lane_ecc_corr, .lane_pcs_err,
   .checksum_error_flag, .lane_frame_lost, .align_restart, .link_aligned, .irq);
`default_nettype wire

// ### tb/rxles_far_tx.sv
// Far-side transmitter model: lane sync words and lane error events.
`timescale 1ns/1ps
`default_nettype none
module rxles_far_tx (
   // Clock.
   input wire logic core_clk,
   // Lane outputs.
   output logic [3:0] ev [0:5],
   output logic [3:0] sync
);
   logic [2:0] tick = 3'h0;
   logic [3:0] sync_mask = 4'hF;
   initial begin
      foreach (ev[i]) ev[i] = 4'h0;
      sync = 4'h0;
   end
   // Sync words go out on the lanes of sync_mask once every eight cycles.
   always @(posedge core_clk) begin
      tick <= tick + 3'h1;
      sync <= (tick == 3'h0) ? sync_mask : 4'h0;
   end
   // Raises one error event on the given lanes for one cycle.
   task automatic send(input int k, input logic [3:0] lanes);
      ev[k] <= lanes;
      @(posedge core_clk);
      ev[k] <= 4'h0;
   endtask : send
endmodule : rxles_far_tx
`default_nettype wire

// ### tb/rx_link_error_status_regs_test.sv
// Testbench for the receive error status register bank.
`timescale 1ns/1ps
`default_nettype none
module rx_link_error_status_regs_test;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [31:0] reg_rdata;
   logic link_aligned, align_restart, irq;
   logic [3:0] ev [0:5];
   logic [3:0] sync;
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   int pos [0:5] = '{10, 9, 8, 4, 3, 2};
   // Clock at 200 MHz.
   always #2.5 core_clk = ~core_clk;
   rxles_far_tx far (.core_clk, .ev, .sync);
   rxles_regs #(.NUM_LANES(4), .RETRY_LIMIT(0)) dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .lane_deskew_over(ev[0]), .lane_ecc_fatal(ev[1]), .lane_ecc_corr(ev[2]),
      .lane_sync_word(sync), .lane_pcs_err(ev[3]), .checksum_error_flag(ev[4]), .lane_frame_lost(ev[5]),
      .link_aligned, .align_restart, .irq);
   // Compares a value with its expectation.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // One-cycle register write.
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   // One-cycle register read; data are checked in the following cycle.
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1 chk("rdata", e, reg_rdata);
      @(posedge core_clk);
   endtask : rd
   // Prints the verdict and ends the run.
   task automatic results;
      if (n_errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   // Cuts a hung run short.
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 1000) begin
         n_errors++;
         results();
      end
   end
   // Main sequence.
   initial begin
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd(16'h00C2, 32'h0);
      rd(16'h00D0, 32'h0);
      rd(16'h00D1, 32'h0);
      wr(16'h00D1, 32'h77C);
      rd(16'h00D1, 32'h77C);
      repeat (20) @(posedge core_clk);
      #1 chk("aligned", 32'h1, {31'h0, link_aligned});
      rd(16'h00D2, 32'h2);
      for (int k = 0; k < 6; k++) begin
         far.send(k, 4'h8 >> (k % 4));
         rd(16'h00D0, 32'h1 << pos[k]);
         #1 chk("irq", 32'h1, {31'h0, irq});
         wr(16'h00D0, 32'h1 << pos[k]);
      end
      #1 chk("irq", 32'h0, {31'h0, irq});
      far.send(5, 4'hF);
      wr(16'h00D0, 32'hFFFFFFFB);
      rd(16'h00D0, 32'h4);
      wr(16'h00D1, 32'h0);
      #1 chk("irq", 32'h0, {31'h0, irq});
      wr(16'h00D1, 32'h4);
      #1 chk("irq", 32'h1, {31'h0, irq});
      wr(16'h00E0, 32'hFFFFFFFF);
      rd(16'h00E0, 32'h0);
      rd(16'h00D1, 32'h4);
      far.sync_mask <= 4'h7;
      repeat (16) @(posedge core_clk);
      far.sync_mask <= 4'hF;
      repeat (16) @(posedge core_clk);
      #1 chk("aligned", 32'h1, {31'h0, link_aligned});
      rd(16'h00D0, 32'h64);
      wr(16'h00C2, 32'h1);
      rd(16'h00C2, 32'h1);
      rd(16'h00D2, 32'h0);
      #1 chk("aligned", 32'h0, {31'h0, link_aligned});
      chk("restart", 32'h1, {31'h0, align_restart});
      wr(16'h00C2, 32'h0);
      repeat (20) @(posedge core_clk);
      #1 chk("aligned", 32'h1, {31'h0, link_aligned});
      chk("restart", 32'h0, {31'h0, align_restart});
      // A second reset in mid-run must bring the status, enable and control registers back to zero.
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd(16'h00D0, 32'h0);
      rd(16'h00D1, 32'h0);
      rd(16'h00C2, 32'h0);
      #1 chk("irq", 32'h0, {31'h0, irq});
      results();
   end
endmodule : rx_link_error_status_regs_test
`default_nettype wire
